// [spd_pkg.sv]
// Shared types and constants for the set point derivation block.
package spd_pkg;
  localparam int LOOP_W = 5;
  localparam int VAL_W = 16;
  localparam int PCT_W = 11;
  localparam logic [PCT_W-1:0] PCT_FULL = 11'h3e8;
  localparam int RATIO_W = 14;
  localparam logic [RATIO_W-1:0] RATIO_MIN = 14'h0001;
  localparam logic [RATIO_W-1:0] RATIO_MAX = 14'h270f;
  localparam int RATIO_SCALE = 10;
  localparam logic signed [VAL_W-1:0] LIMIT_POS = 16'sh270f;
  localparam logic signed [VAL_W-1:0] LIMIT_NEG = -16'sh270f;
  localparam logic [LOOP_W-1:0] LOOP_NONE = 5'h1f;
  localparam int DP_W = 2;
  localparam int CALC_LATENCY = 2;

  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_CASCADE = 2'b01,
    MODE_RATIO = 2'b11
  } loop_mode_t;

  typedef struct packed {
    loop_mode_t mode;
    logic [LOOP_W-1:0] primary_loop_select;
    logic [LOOP_W-1:0] master_loop_select;
    logic signed [VAL_W-1:0] cascade_base_value;
    logic signed [VAL_W-1:0] heat_output_span;
    logic signed [VAL_W-1:0] cool_output_span;
    logic [RATIO_W-1:0] control_ratio;
    logic signed [VAL_W-1:0] setpoint_offset;
    logic [DP_W-1:0] decimal_display_format;
    logic signed [VAL_W-1:0] setpoint_floor;
    logic signed [VAL_W-1:0] setpoint_ceiling;
    logic signed [VAL_W-1:0] pv_low_limit;
    logic signed [VAL_W-1:0] pv_high_limit;
  } loop_cfg_t;

  typedef struct packed {
    logic signed [VAL_W-1:0] setpoint;
    logic valid;
    logic clamped;
    logic cfg_error;
  } sp_result_t;
endpackage : spd_pkg

// [spd_clamp.sv]
// Clamps a wide signed value between a floor and a ceiling and flags clamping.
module spd_clamp #(
  parameter int IN_W = 40,
  parameter int OUT_W = 16
) (
  input wire logic signed [IN_W-1:0] value_i,
  input wire logic signed [OUT_W-1:0] floor_i,
  input wire logic signed [OUT_W-1:0] ceiling_i,
  output logic signed [OUT_W-1:0] result_o,
  output logic clamped_o
);
  logic signed [IN_W-1:0] floor_w;
  logic signed [IN_W-1:0] ceil_w;

  always_comb begin
    floor_w = IN_W'(floor_i);
    ceil_w = IN_W'(ceiling_i);
    if (value_i < floor_w) begin
      result_o = floor_i;
      clamped_o = 1'b1;
    end else if (value_i > ceil_w) begin
      result_o = ceiling_i;
      clamped_o = 1'b1;
    end else begin
      result_o = value_i[OUT_W-1:0];
      clamped_o = 1'b0;
    end
  end
endmodule : spd_clamp

// [loop_setpoint_derivation.sv]
// Derives one loop's set point from another loop by cascade or ratio.
//
// How it works
// [RULE1] Cascade set point rises as primary output percentage rises.
// [RULE2] Zero percent primary output gives exactly the cascade base value.
// [RULE3] Cascade increase equals output fraction times span, added to base.
// [RULE4] Output saturated at full scale holds set point at base plus span.
// [RULE5] Ratio set point is master process variable times control ratio.
// [RULE6] Any loop's process variable except this loop's may be the ratio master.
// [RULE7] One loop is cascade or ratio, never both; loops differ freely.
// [RULE8] Master may not be this loop; none disables ratio derivation.
// [RULE9] Results below the floor are replaced by the floor.
// [RULE10] Results above the ceiling are replaced by the ceiling.
// [RULE11] Floor and ceiling are confined to process variable limits.
// [RULE12] Control ratio accepted from 0.1 to 999.9 in tenths.
// [RULE13] Signed offset, at most 9999 counts, adds to the ratio product.
// [RULE14] Offset decimal point follows the loop display format.
// [RULE15] Remote analog set point reuses the ratio path with analog master.
// [RULE16] A master input of any configured type is accepted.
// [RULE17] Cool output percentage is multiplied by a separate cool span.
// [RULE18] Heat and cool spans are limited to plus or minus 9999.
// [RULE19] Cascade floor and ceiling override the derived set point.
// [RULE20] Primary selection may be any loop except this loop.
// [RULE21] Clamp follows offset; products carried wide enough not to overflow.
// [RULE22] Every control cycle recomputes from current source values.
module loop_setpoint_derivation #(
  parameter int NUM_LOOPS = 16
) (
  input wire logic MCLK_I,
  input wire logic SYS_RST_I,
  input wire logic CYCLE_STROBE_I,
  input wire logic [spd_pkg::LOOP_W-1:0] OWN_LOOP_I,
  input wire spd_pkg::loop_cfg_t CFG_I,
  input wire logic [NUM_LOOPS*spd_pkg::VAL_W-1:0] PV_BUS_I,
  input wire logic [NUM_LOOPS*spd_pkg::PCT_W-1:0] HEAT_PCT_BUS_I,
  input wire logic [NUM_LOOPS*spd_pkg::PCT_W-1:0] COOL_PCT_BUS_I,
  output spd_pkg::sp_result_t RESULT_O
);
  import spd_pkg::*;

  localparam int PROD_W = 40;

  // Selects one field of a packed per-loop bus; out-of-range picks read zero.
  function automatic logic [VAL_W-1:0] pick_val(input logic [NUM_LOOPS*VAL_W-1:0] bus,
                                                 input logic [LOOP_W-1:0] idx);
    logic [VAL_W-1:0] r;
    r = '0;
    for (int i = 0; i < NUM_LOOPS; i++) begin
      if (idx == LOOP_W'(i)) begin
        r = bus[i*VAL_W +: VAL_W];
      end
    end
    return r;
  endfunction : pick_val

  function automatic logic [PCT_W-1:0] pick_pct(input logic [NUM_LOOPS*PCT_W-1:0] bus,
                                                 input logic [LOOP_W-1:0] idx);
    logic [PCT_W-1:0] r;
    r = '0;
    for (int i = 0; i < NUM_LOOPS; i++) begin
      if (idx == LOOP_W'(i)) begin
        r = bus[i*PCT_W +: PCT_W];
      end
    end
    return r;
  endfunction : pick_pct

  // Saturates a signed value to plus or minus 9999 counts.
  function automatic logic signed [VAL_W-1:0] limit9999(input logic signed [VAL_W-1:0] v);
    if (v > LIMIT_POS) begin
      return LIMIT_POS;
    end else if (v < LIMIT_NEG) begin
      return LIMIT_NEG;
    end
    return v;
  endfunction : limit9999

  // Percentages are tenths of a percent and saturate at full scale.
  function automatic logic [PCT_W-1:0] sat_pct(input logic [PCT_W-1:0] p);
    return (p > PCT_FULL) ? PCT_FULL : p;
  endfunction : sat_pct

  // Configuration checks and source selection.
  logic sel_ok;
  logic lim_ok;
  logic ratio_ok;
  logic cfg_bad;
  logic signed [VAL_W-1:0] floor_eff;
  logic signed [VAL_W-1:0] ceil_eff;
  logic [RATIO_W-1:0] ratio_eff;
  logic signed [VAL_W-1:0] heat_span;
  logic signed [VAL_W-1:0] cool_span;
  logic signed [VAL_W-1:0] offset_eff;
  logic [PCT_W-1:0] heat_pct;
  logic [PCT_W-1:0] cool_pct;
  logic signed [VAL_W-1:0] master_pv;

  always_comb begin
    // A single mode field makes cascade and ratio mutually exclusive per loop. [RULE7]
    sel_ok = 1'b0;
    if (CFG_I.mode == MODE_CASCADE) begin
      sel_ok = (CFG_I.primary_loop_select != OWN_LOOP_I) && // [RULE20]
               (32'(CFG_I.primary_loop_select) < NUM_LOOPS);
    end else if (CFG_I.mode == MODE_RATIO) begin
      sel_ok = (CFG_I.master_loop_select != LOOP_NONE) && // [RULE8]
               (CFG_I.master_loop_select != OWN_LOOP_I) && // [RULE8]
               (32'(CFG_I.master_loop_select) < NUM_LOOPS); // [RULE6]
    end
    // Floor and ceiling are pulled inside the process variable limits. [RULE11]
    floor_eff = CFG_I.setpoint_floor;
    ceil_eff = CFG_I.setpoint_ceiling;
    lim_ok = (CFG_I.pv_low_limit <= CFG_I.pv_high_limit);
    if (floor_eff < CFG_I.pv_low_limit) begin
      floor_eff = CFG_I.pv_low_limit;
    end
    if (floor_eff > CFG_I.pv_high_limit) begin
      floor_eff = CFG_I.pv_high_limit;
    end
    if (ceil_eff > CFG_I.pv_high_limit) begin
      ceil_eff = CFG_I.pv_high_limit;
    end
    if (ceil_eff < CFG_I.pv_low_limit) begin
      ceil_eff = CFG_I.pv_low_limit;
    end
    // Ratio is held inside 0.1 to 999.9 in tenths. [RULE12]
    ratio_ok = (CFG_I.control_ratio >= RATIO_MIN) && (CFG_I.control_ratio <= RATIO_MAX);
    ratio_eff = CFG_I.control_ratio;
    if (CFG_I.control_ratio < RATIO_MIN) begin
      ratio_eff = RATIO_MIN;
    end else if (CFG_I.control_ratio > RATIO_MAX) begin
      ratio_eff = RATIO_MAX;
    end
    heat_span = limit9999(CFG_I.heat_output_span); // [RULE18]
    cool_span = limit9999(CFG_I.cool_output_span); // [RULE18]
    // The offset is in raw display counts, so its decimal point is the loop's own format. [RULE14]
    offset_eff = limit9999(CFG_I.setpoint_offset); // [RULE13]
    cfg_bad = !lim_ok || (CFG_I.mode == MODE_RATIO && !ratio_ok);
    heat_pct = sat_pct(pick_pct(HEAT_PCT_BUS_I, CFG_I.primary_loop_select)); // [RULE4]
    cool_pct = sat_pct(pick_pct(COOL_PCT_BUS_I, CFG_I.primary_loop_select)); // [RULE4]
    // Any input type feeds the master path; remote analog is just a master loop. [RULE15] [RULE16]
    master_pv = signed'(pick_val(PV_BUS_I, CFG_I.master_loop_select)); // [RULE6]
  end

  // Stage one: wide products.
  logic signed [PROD_W-1:0] heat_prod;
  logic signed [PROD_W-1:0] cool_prod;
  logic signed [PROD_W-1:0] ratio_prod;
  logic signed [PROD_W-1:0] next_heat_prod;
  logic signed [PROD_W-1:0] next_cool_prod;
  logic signed [PROD_W-1:0] next_ratio_prod;
  logic stage1_valid;
  logic next_stage1_valid;
  loop_mode_t stage1_mode;
  loop_mode_t next_stage1_mode;
  logic stage1_bad;
  logic next_stage1_bad;
  logic signed [VAL_W-1:0] stage1_base;
  logic signed [VAL_W-1:0] next_stage1_base;
  logic signed [VAL_W-1:0] stage1_offset;
  logic signed [VAL_W-1:0] next_stage1_offset;
  logic signed [VAL_W-1:0] stage1_floor;
  logic signed [VAL_W-1:0] next_stage1_floor;
  logic signed [VAL_W-1:0] stage1_ceil;
  logic signed [VAL_W-1:0] next_stage1_ceil;

  always_comb begin
    next_stage1_valid = CYCLE_STROBE_I; // [RULE22]
    next_heat_prod = heat_prod;
    next_cool_prod = cool_prod;
    next_ratio_prod = ratio_prod;
    next_stage1_mode = stage1_mode;
    next_stage1_bad = stage1_bad;
    next_stage1_base = stage1_base;
    next_stage1_offset = stage1_offset;
    next_stage1_floor = stage1_floor;
    next_stage1_ceil = stage1_ceil;
    if (CYCLE_STROBE_I) begin
      // Percent tenths times span; zero output adds nothing. [RULE1] [RULE2] [RULE3]
      next_heat_prod = PROD_W'(signed'({1'b0, heat_pct}) * heat_span); // [RULE3]
      next_cool_prod = PROD_W'(signed'({1'b0, cool_pct}) * cool_span); // [RULE17]
      next_ratio_prod = PROD_W'(master_pv * signed'({1'b0, ratio_eff})); // [RULE5] [RULE21]
      next_stage1_mode = sel_ok ? CFG_I.mode : MODE_OFF; // [RULE8]
      next_stage1_bad = cfg_bad;
      next_stage1_base = CFG_I.cascade_base_value;
      next_stage1_offset = offset_eff;
      next_stage1_floor = floor_eff;
      next_stage1_ceil = ceil_eff;
    end
  end

  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      heat_prod <= '0;
      cool_prod <= '0;
      ratio_prod <= '0;
      stage1_valid <= 1'b0;
      stage1_mode <= MODE_OFF;
      stage1_bad <= 1'b0;
      stage1_base <= '0;
      stage1_offset <= '0;
      stage1_floor <= '0;
      stage1_ceil <= '0;
    end else begin
      heat_prod <= next_heat_prod;
      cool_prod <= next_cool_prod;
      ratio_prod <= next_ratio_prod;
      stage1_valid <= next_stage1_valid;
      stage1_mode <= next_stage1_mode;
      stage1_bad <= next_stage1_bad;
      stage1_base <= next_stage1_base;
      stage1_offset <= next_stage1_offset;
      stage1_floor <= next_stage1_floor;
      stage1_ceil <= next_stage1_ceil;
    end
  end

  // Stage two: scale, add base or offset, clamp.
  logic signed [PROD_W-1:0] raw_sum;
  logic signed [VAL_W-1:0] clamped_val;
  logic clamp_hit;

  always_comb begin
    if (stage1_mode == MODE_CASCADE) begin
      raw_sum = PROD_W'(stage1_base) + (heat_prod + cool_prod) / signed'(PROD_W'(PCT_FULL)); // [RULE3]
    end else begin
      // Offset goes in before the clamp. [RULE13] [RULE21]
      raw_sum = ratio_prod / PROD_W'(RATIO_SCALE) + PROD_W'(stage1_offset);
    end
  end

  spd_clamp #(
    .IN_W(PROD_W),
    .OUT_W(VAL_W)
  ) u_clamp (
    .value_i(raw_sum),
    .floor_i(stage1_floor),
    .ceiling_i(stage1_ceil),
    .result_o(clamped_val),
    .clamped_o(clamp_hit)
  ); // [RULE9] [RULE10] [RULE19]

  sp_result_t result;
  sp_result_t next_result;

  always_comb begin
    next_result = result;
    next_result.valid = 1'b0;
    if (stage1_valid) begin
      next_result.valid = (stage1_mode != MODE_OFF) && !stage1_bad;
      next_result.cfg_error = stage1_bad;
      next_result.clamped = 1'b0;
      if (stage1_mode != MODE_OFF && !stage1_bad) begin
        next_result.setpoint = clamped_val; // [RULE22]
        next_result.clamped = clamp_hit;
      end
    end
  end

  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      result <= '0;
    end else begin
      result <= next_result;
    end
  end

  assign RESULT_O = result;

  clamp_floor_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I) // [RULE9]
    (stage1_valid && stage1_mode != MODE_OFF && !stage1_bad && raw_sum < PROD_W'(stage1_floor))
    |=> (RESULT_O.setpoint == $past(stage1_floor) && RESULT_O.clamped))
    else $error("Set point not held at floor.");

  clamp_ceiling_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I) // [RULE10]
    (stage1_valid && stage1_mode != MODE_OFF && !stage1_bad && raw_sum > PROD_W'(stage1_ceil)
     && stage1_floor <= stage1_ceil)
    |=> (RESULT_O.setpoint == $past(stage1_ceil)))
    else $error("Set point not held at ceiling.");

  result_latency_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I) // [RULE22]
    RESULT_O.valid |-> $past(CYCLE_STROBE_I, CALC_LATENCY))
    else $error("Result valid without a cycle strobe.");

  cascade_zero_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I) // [RULE2]
    (stage1_valid && stage1_mode == MODE_CASCADE && !stage1_bad && heat_prod == 0 && cool_prod == 0
     && stage1_base >= stage1_floor && stage1_base <= stage1_ceil)
    |=> RESULT_O.setpoint == $past(stage1_base))
    else $error("Zero output did not give base value.");

  self_master_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I) // [RULE8]
    (CYCLE_STROBE_I && CFG_I.mode == MODE_RATIO && CFG_I.master_loop_select == OWN_LOOP_I)
    |-> ##2 !RESULT_O.valid)
    else $error("Ratio derived from own loop.");

  self_primary_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I) // [RULE20]
    (CYCLE_STROBE_I && CFG_I.mode == MODE_CASCADE && CFG_I.primary_loop_select == OWN_LOOP_I)
    |-> ##2 !RESULT_O.valid)
    else $error("Cascade derived from own loop.");

  ratio_range_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I) // [RULE12]
    (CYCLE_STROBE_I && CFG_I.mode == MODE_RATIO && !ratio_ok) |-> ##2 RESULT_O.cfg_error)
    else $error("Out-of-range ratio not flagged.");

  inside_limits_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I) // [RULE11]
    (CYCLE_STROBE_I && lim_ok) |-> (floor_eff >= CFG_I.pv_low_limit && ceil_eff <= CFG_I.pv_high_limit))
    else $error("Floor or ceiling outside limits.");

  // The checks below watch this block's answer, some against its inputs or its stage one registers.
  valid_not_error_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I) // [RULE12]
    RESULT_O.cfg_error |-> !RESULT_O.valid)
    else $error("Result valid while a configuration error is shown.");

  mode_off_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I) // [RULE7]
    (CYCLE_STROBE_I && CFG_I.mode == MODE_OFF) |-> ##2 !RESULT_O.valid)
    else $error("Result given with no mode selected.");

  master_none_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I) // [RULE8]
    (CYCLE_STROBE_I && CFG_I.mode == MODE_RATIO && CFG_I.master_loop_select == LOOP_NONE)
    |-> ##2 !RESULT_O.valid)
    else $error("Ratio result given with no master loop.");

  setpoint_hold_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I) // [RULE22]
    !RESULT_O.valid |-> $stable(RESULT_O.setpoint))
    else $error("Set point changed without a new result.");

  result_window_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I) // [RULE9] [RULE10]
    (RESULT_O.valid && !RESULT_O.clamped)
    |-> (RESULT_O.setpoint >= $past(stage1_floor) && RESULT_O.setpoint <= $past(stage1_ceil)))
    else $error("Unclamped set point outside floor and ceiling.");

  valid_needs_mode_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I) // [RULE7]
    RESULT_O.valid |-> ($past(stage1_mode) != MODE_OFF))
    else $error("Result valid from a loop with no mode.");

  cascade_run_c: cover property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    stage1_valid && stage1_mode == MODE_CASCADE ##1 RESULT_O.valid);
  ratio_run_c: cover property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    stage1_valid && stage1_mode == MODE_RATIO ##1 RESULT_O.valid);
  clamp_hit_c: cover property (@(posedge MCLK_I) disable iff (SYS_RST_I) RESULT_O.valid && RESULT_O.clamped);
  config_error_c: cover property (@(posedge MCLK_I) disable iff (SYS_RST_I) RESULT_O.cfg_error);
  back_to_back_c: cover property (@(posedge MCLK_I) disable iff (SYS_RST_I) RESULT_O.valid ##1 RESULT_O.valid);
endmodule : loop_setpoint_derivation

// [loop_setpoint_derivation_test.sv]
// Self-checking randomised bench for the loop set point derivation block.
module loop_setpoint_derivation_test;
  timeunit 1ns;
  timeprecision 100ps;
  import spd_pkg::*;

  localparam int NL = 16;
  typedef struct packed {
    logic valid;
    logic err;
    logic clamped;
    logic signed [VAL_W-1:0] sp;
  } exp_t;

  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic strobe = 1'b0;
  logic [LOOP_W-1:0] own_v = '0;
  loop_cfg_t cfg_v = '0;
  logic [NL*VAL_W-1:0] pv_v = '0;
  logic [NL*PCT_W-1:0] heat_v = '0;
  logic [NL*PCT_W-1:0] cool_v = '0;
  sp_result_t res;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  logic signed [VAL_W-1:0] last_sp = '0;
  exp_t exp_q[$];
  int due_q[$];

  loop_setpoint_derivation #(.NUM_LOOPS(NL)) DUT (.MCLK_I(mclk), .SYS_RST_I(rst), .CYCLE_STROBE_I(strobe),
    .OWN_LOOP_I(own_v), .CFG_I(cfg_v), .PV_BUS_I(pv_v), .HEAT_PCT_BUS_I(heat_v), .COOL_PCT_BUS_I(cool_v),
    .RESULT_O(res));

  always #2.5 mclk = ~mclk;

  function automatic longint sat(input longint x);
    return (x > 9999) ? 9999 : ((x < -9999) ? -9999 : x);
  endfunction : sat

  function automatic longint pct(input logic [PCT_W-1:0] p);
    return (p > PCT_FULL) ? longint'(PCT_FULL) : longint'(p);
  endfunction : pct

  function automatic logic [VAL_W-1:0] rnd(input int lo, input int hi);
    int r;
    r = lo + int'($urandom_range(hi - lo));
    return r[VAL_W-1:0];
  endfunction : rnd

  // Expected result of one computation from the inputs seen at the strobe edge.
  function automatic exp_t exp_calc(input loop_cfg_t c, input logic [LOOP_W-1:0] own);
    exp_t e;
    logic [LOOP_W-1:0] s;
    longint v;
    longint fl;
    longint ce;
    e = '0;
    s = (c.mode == MODE_RATIO) ? c.master_loop_select : c.primary_loop_select;
    if ((c.mode != MODE_RATIO && c.mode != MODE_CASCADE) || s == own || s >= NL) return e;
    if (c.pv_low_limit > c.pv_high_limit || (c.mode == MODE_RATIO && (c.control_ratio < RATIO_MIN ||
        c.control_ratio > RATIO_MAX))) begin
      e.err = 1'b1;
      return e;
    end
    if (c.mode == MODE_CASCADE) begin
      v = c.cascade_base_value + (pct(heat_v[s*PCT_W +: PCT_W]) * sat(c.heat_output_span) +
          pct(cool_v[s*PCT_W +: PCT_W]) * sat(c.cool_output_span)) / 1000;
    end else begin
      v = longint'($signed(pv_v[s*VAL_W +: VAL_W])) * longint'(c.control_ratio) / 10 + sat(c.setpoint_offset);
    end
    fl = (c.setpoint_floor > c.pv_low_limit) ? c.setpoint_floor : c.pv_low_limit;
    ce = (c.setpoint_ceiling < c.pv_high_limit) ? c.setpoint_ceiling : c.pv_high_limit;
    fl = (fl > c.pv_high_limit) ? longint'(c.pv_high_limit) : fl;
    ce = (ce < c.pv_low_limit) ? longint'(c.pv_low_limit) : ce;
    e.valid = 1'b1;
    e.clamped = (v < fl) || (v > ce);
    v = (v < fl) ? fl : ((v > ce) ? ce : v);
    e.sp = v[VAL_W-1:0];
    return e;
  endfunction : exp_calc

  function automatic loop_cfg_t base_cfg(input loop_mode_t m, input logic [LOOP_W-1:0] sel);
    loop_cfg_t c;
    c = '0;
    c.mode = m;
    c.primary_loop_select = sel;
    c.master_loop_select = sel;
    c.control_ratio = 14'h000a;
    c.setpoint_floor = LIMIT_NEG;
    c.setpoint_ceiling = LIMIT_POS;
    c.pv_low_limit = LIMIT_NEG;
    c.pv_high_limit = LIMIT_POS;
    return c;
  endfunction : base_cfg

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic send(input loop_cfg_t c);
    cfg_v = c;
    strobe = 1'b1;
    @(posedge mclk);
    #1;
  endtask : send

  task automatic idle(input int n);
    strobe = 1'b0;
    repeat (n) @(posedge mclk);
    #1;
  endtask : idle

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  // Scoreboard: records each taken request and checks the answer just after the next edge.
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (!rst && strobe) begin
      exp_q.push_back(exp_calc(cfg_v, own_v));
      // The answer is registered at the edge after the strobe edge and read just after that edge.
      due_q.push_back(cyc + CALC_LATENCY - 1);
    end
  end

  always begin : monitor
    exp_t e;
    @(posedge mclk);
    #1;
    if (!rst) begin
      if (due_q.size() > 0 && due_q[0] == cyc) begin
        e = exp_q.pop_front();
        void'(due_q.pop_front());
        check("valid", 32'(res.valid), 32'(e.valid));
        check("setpoint", res.setpoint, e.valid ? e.sp : last_sp);
        if (e.valid) begin
          check("clamped", 32'(res.clamped), 32'(e.clamped));
          last_sp = e.sp;
        end
        if (e.valid || e.err) check("cfg_error", 32'(res.cfg_error), 32'(e.err));
      end else begin
        check("idle valid", 32'(res.valid), 32'h0);
      end
    end
  end

  initial begin
    #20000;
    err_total++;
    test_done();
  end

  initial begin : main
    loop_cfg_t c;
    static int hp[5] = '{0, 100, 500, 1000, 1500};
    static int rt[4] = '{1, 9999, 10, 10};
    static int of[4] = '{9999, -9999, 12000, -12000};
    static int pl[3] = '{50, 200, 400};
    void'($urandom(32'h9af7));
    repeat (2) @(posedge mclk);
    #1;
    rst = 1'b0;
    @(posedge mclk);
    #1;
    check("reset result", 32'(res), 32'h0);
    own_v = 5'h02;
    c = base_cfg(MODE_CASCADE, 5'h01);
    c.cascade_base_value = 16'sh0096;
    c.heat_output_span = 16'sh0028;
    c.setpoint_floor = -16'sh015e;
    c.setpoint_ceiling = 16'sh0578;
    for (int i = 0; i < 5; i++) begin
      heat_v[PCT_W +: PCT_W] = PCT_W'(hp[i]);
      send(c);
      idle(3);
    end
    heat_v[PCT_W +: PCT_W] = 11'h1f4;
    cool_v[PCT_W +: PCT_W] = 11'h12c;
    c.cool_output_span = -16'sh0032;
    send(c);
    c.heat_output_span = 16'sh7fff;
    send(c);
    idle(3);
    $display("test cascade done");
    c = base_cfg(MODE_RATIO, 5'h00);
    c.control_ratio = 14'h0005;
    for (int i = 0; i < NL; i++) pv_v[i*VAL_W +: VAL_W] = VAL_W'(i * 100 - 707);
    for (int i = 0; i < NL; i++) begin
      c.master_loop_select = LOOP_W'(i);
      if (i != 2) send(c);
    end
    c.master_loop_select = 5'h01;
    for (int i = 0; i < 4; i++) begin
      c.control_ratio = RATIO_W'(rt[i]);
      c.setpoint_offset = VAL_W'(of[i]);
      send(c);
    end
    c.setpoint_offset = '0;
    for (int k = 0; k < 6; k++) begin
      c.setpoint_floor = (k < 3) ? 16'sh0064 : -16'sh2328;
      c.setpoint_ceiling = (k < 3) ? 16'sh012c : 16'sh2328;
      c.pv_low_limit = (k < 3) ? LIMIT_NEG : 16'sh0064;
      c.pv_high_limit = (k < 3) ? LIMIT_POS : 16'sh012c;
      pv_v[VAL_W +: VAL_W] = VAL_W'(pl[k % 3]);
      send(c);
    end
    c.setpoint_floor = 16'sh01f4;
    c.setpoint_ceiling = -16'sh01f4;
    send(c);
    idle(3);
    $display("test ratio done");
    c = base_cfg(MODE_OFF, 5'h01);
    send(c);
    c = base_cfg(MODE_RATIO, 5'h02);
    send(c);
    c.master_loop_select = LOOP_NONE;
    send(c);
    c.master_loop_select = 5'h14;
    send(c);
    c = base_cfg(MODE_CASCADE, 5'h02);
    send(c);
    c = base_cfg(MODE_RATIO, 5'h03);
    c.control_ratio = 14'h0000;
    send(c);
    c.control_ratio = 14'h2710;
    send(c);
    c.control_ratio = 14'h000a;
    c.pv_low_limit = 16'sh0064;
    c.pv_high_limit = 16'sh0000;
    send(c);
    idle(3);
    $display("test refusal done");
    repeat (200) begin
      for (int i = 0; i < NL; i++) begin
        pv_v[i*VAL_W +: VAL_W] = rnd(-4000, 4000);
        heat_v[i*PCT_W +: PCT_W] = PCT_W'($urandom_range(1100));
        cool_v[i*PCT_W +: PCT_W] = PCT_W'($urandom_range(1100));
      end
      own_v = LOOP_W'($urandom_range(15));
      c.mode = ($urandom_range(3) == 0) ? MODE_OFF : (($urandom_range(1) == 1) ? MODE_CASCADE : MODE_RATIO);
      c.primary_loop_select = LOOP_W'($urandom_range(17));
      c.master_loop_select = LOOP_W'($urandom_range(17));
      c.cascade_base_value = rnd(-3000, 3000);
      c.heat_output_span = rnd(-12000, 12000);
      c.cool_output_span = rnd(-12000, 12000);
      c.control_ratio = RATIO_W'($urandom_range(9999, 1));
      c.setpoint_offset = rnd(-12000, 12000);
      c.decimal_display_format = DP_W'($urandom_range(3));
      c.setpoint_floor = rnd(-5000, 0);
      c.setpoint_ceiling = rnd(0, 5000);
      c.pv_low_limit = rnd(-6000, -1000);
      c.pv_high_limit = rnd(1000, 6000);
      send(c);
      if ($urandom_range(3) == 0) idle(1);
    end
    idle(4);
    $display("test random done");
    test_done();
  end
endmodule : loop_setpoint_derivation_test
